// File: design/rlgc_pkg.sv
// Package with register map, field layout, reset values and carrier types for the ring and group config bank.
package rlgc_pkg;

    // Number of links, groups and pair registers.
    localparam int unsigned NUM_LINKS  = 16;
    localparam int unsigned NUM_GROUPS = 8;
    localparam int unsigned NUM_PAIRS  = 8;

    // APB geometry: word index in paddr[11:2], 32-bit data, 16 meaningful bits.
    localparam int unsigned APB_ADDR_W = 12;
    localparam int unsigned APB_DATA_W = 32;
    localparam int unsigned REG_W      = 16;
    localparam int unsigned IDX_W      = 10;

    // Register indices as printed; byte address is four times the index.
    localparam logic [IDX_W-1:0] TX_RING_FIRST_IDX  = 10'h181;
    localparam logic [IDX_W-1:0] TX_RING_LAST_IDX   = 10'h190;
    localparam logic [IDX_W-1:0] RX_RING_FIRST_IDX  = 10'h1c0;
    localparam logic [IDX_W-1:0] RX_RING_LAST_IDX   = 10'h1cf;
    localparam logic [IDX_W-1:0] PAIR_GRP_FIRST_IDX = 10'h201;
    localparam logic [IDX_W-1:0] PAIR_GRP_LAST_IDX  = 10'h208;
    localparam logic [IDX_W-1:0] REF_SEL_FIRST_IDX  = 10'h209;
    localparam logic [IDX_W-1:0] REF_SEL_LAST_IDX   = 10'h210;

    // Ring routing fields (transmit and receive share one layout).
    localparam int unsigned RING_ATM_MODE_BIT = 11;
    localparam int unsigned RING_ATM_ADDR_LSB = 6;
    localparam int unsigned RING_TDM_MODE_BIT = 5;
    localparam int unsigned RING_TDM_ADDR_LSB = 0;
    localparam int unsigned RING_CFG_W        = 12;

    // Pair group assignment fields.
    localparam int unsigned PAIR_HI_EN_BIT  = 12;
    localparam int unsigned PAIR_HI_GRP_LSB = 8;
    localparam int unsigned PAIR_LO_EN_BIT  = 4;
    localparam int unsigned PAIR_LO_GRP_LSB = 0;
    localparam int unsigned PAIR_HI_LINK_OFS = 8;

    // Reference link select fields.
    localparam int unsigned REF_AUTO_BIT   = 4;
    localparam int unsigned REF_LINK_LSB   = 0;
    localparam int unsigned REF_EFF_LSB    = 5;
    localparam int unsigned REF_CFG_W      = 5;

    // Reset values.
    localparam logic [REG_W-1:0] TX_RING_RESET  = 16'h0000;
    localparam logic [REG_W-1:0] RX_RING_RESET  = 16'h0000;
    localparam logic [REG_W-1:0] PAIR_GRP_RESET = 16'h0000;
    localparam logic [REG_W-1:0] REF_SEL_RESET  = 16'h0000;

    // Ring routing of one link; packs exactly onto bits 11:0 of the register.
    typedef struct packed {
        logic       atm_ring;
        logic [4:0] atm_addr;
        logic       tdm_ring;
        logic [4:0] tdm_addr;
    } rlgc_ring_cfg_t;

    // Recombiner enable and group of one receive link.
    typedef struct packed {
        logic       enable;
        logic [2:0] group;
    } rlgc_rcmb_cfg_t;

    // Reference link programming of one group; packs onto bits 4:0.
    typedef struct packed {
        logic       auto_sel;
        logic [3:0] link;
    } rlgc_ref_cfg_t;

    // Reference link in force for one group.
    typedef struct packed {
        logic       valid;
        logic [3:0] link;
    } rlgc_ref_out_t;

endpackage

// File: design/rlgc_ref_pick.sv
// Reference link chooser: per group, automatic pick or the programmed link.
`timescale 1ns/10ps
`default_nettype none

module rlgc_ref_pick
    import rlgc_pkg::*;
#(
    parameter int unsigned N_LINKS  = NUM_LINKS,
    parameter int unsigned N_GROUPS = NUM_GROUPS
) (
    input  wire rlgc_rcmb_cfg_t i_rcmb  [N_LINKS],
    input  wire logic [N_LINKS-1:0] i_link_up,
    input  wire rlgc_ref_cfg_t  i_ref   [N_GROUPS],
    output rlgc_ref_out_t       o_ref   [N_GROUPS]
);

    genvar g;
    generate
        for (g = 0; g < N_GROUPS; g++) begin : gen_group
            // Automatic mode takes the lowest numbered enabled, live member.
            always_comb begin
                o_ref[g] = '{valid: 1'b0, link: 4'h0};
                if (i_ref[g].auto_sel) begin
                    for (int l = N_LINKS - 1; l >= 0; l--) begin
                        if (i_rcmb[l].enable && i_link_up[l] && (i_rcmb[l].group == 3'(g))) begin
                            o_ref[g].valid = 1'b1;
                            o_ref[g].link  = 4'(l);
                        end
                    end
                end else begin
                    o_ref[g].valid = 1'b1;
                    o_ref[g].link  = i_ref[g].link;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// File: design/rlgc_regbank.sv
// Ring routing, receive pair group assignment and reference link register bank on APB.
//
// Contract
// - Transmit ATM ring bit set routes the ring into the control cell modifier.
// - Each transmit link register holds a five-bit ATM-side ring slot address.
// - Transmit TDM ring bit set connects the ring to that TDM transmit interface.
// - Each transmit link register holds a five-bit TDM-side ring slot address.
// - Receive ATM ring bit set connects the ring to the receive link group logic.
// - Each receive link register holds a five-bit ATM-side ring slot address.
// - Receive TDM ring bit set connects the ring to that TDM receive interface.
// - Each receive link register holds a five-bit TDM-side ring slot address.
// - Sixteen transmit link ring registers, each reset to zero.
// - Sixteen receive link ring registers, each reset to zero.
// - Eight pair registers: link N in low byte, link N plus eight high.
// - Bit 12 enables recombining for link N plus eight, bit 4 for link N.
// - Bits 10:8 give the group number of link N plus eight.
// - Bits 2:0 give the group number of link N.
// - Automatic reference bit set lets the device pick the group reference link.
// - Four-bit field holds the fixed reference link when automatic is off.
// - Eight reference link registers, one per group, reset to zero.
// - Unused upper bits 15:13 of pair registers read as zero.
// - Ring output drivers are enabled only while global ring enable is set; here o_ring_oe is its registered copy, one cycle late.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module rlgc_regbank
    import rlgc_pkg::*;
#(
    parameter int unsigned N_LINKS  = NUM_LINKS,
    parameter int unsigned N_GROUPS = NUM_GROUPS,
    parameter int unsigned N_PAIRS  = NUM_PAIRS
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_resetn,
    // APB slave.
    input  wire logic [APB_ADDR_W-1:0] i_paddr,
    input  wire logic                  i_psel,
    input  wire logic                  i_penable,
    input  wire logic                  i_pwrite,
    input  wire logic [APB_DATA_W-1:0] i_pwdata,
    input  wire logic [3:0]            i_pstrb,
    output logic      [APB_DATA_W-1:0] o_prdata,
    output logic                       o_pready,
    output logic                       o_pslverr,
    // Status from neighbouring logic on the same clock.
    input  wire logic                  i_ring_enable,
    input  wire logic [N_LINKS-1:0]    i_link_up,
    // Configuration towards the datapath.
    output rlgc_ring_cfg_t             o_tx_ring [N_LINKS],
    output rlgc_ring_cfg_t             o_rx_ring [N_LINKS],
    output rlgc_rcmb_cfg_t             o_rcmb    [N_LINKS],
    output rlgc_ref_out_t              o_ref     [N_GROUPS],
    output logic [N_LINKS-1:0]         o_tx_atm_ring_sel,
    output logic [N_LINKS-1:0]         o_tx_tdm_ring_sel,
    output logic [N_LINKS-1:0]         o_rx_atm_ring_sel,
    output logic [N_LINKS-1:0]         o_rx_tdm_ring_sel,
    output logic                       o_ring_oe
);

    // Stored configuration.
    rlgc_ring_cfg_t tx_ring_reg [N_LINKS];
    rlgc_ring_cfg_t rx_ring_reg [N_LINKS];
    rlgc_rcmb_cfg_t rcmb_reg    [N_LINKS];
    rlgc_ref_cfg_t  ref_cfg_reg [N_GROUPS];

    // Bus answer registers.
    logic [APB_DATA_W-1:0] prdata_reg;
    logic [APB_DATA_W-1:0] prdata_next;
    logic                  pready_reg;
    logic                  pslverr_reg;
    logic                  pslverr_next;

    // Derived outputs, all registered.
    rlgc_ref_out_t         ref_out_next [N_GROUPS];
    rlgc_ref_out_t         ref_out_reg  [N_GROUPS];
    logic [N_LINKS-1:0]    tx_atm_sel_reg;
    logic [N_LINKS-1:0]    tx_tdm_sel_reg;
    logic [N_LINKS-1:0]    rx_atm_sel_reg;
    logic [N_LINKS-1:0]    rx_tdm_sel_reg;
    logic                  ring_oe_reg;

    // Address decode.
    logic [IDX_W-1:0]      word_idx;
    logic [IDX_W-1:0]      idx_ofs;
    logic                  hit_tx;
    logic                  hit_rx;
    logic                  hit_pair;
    logic                  hit_ref;
    logic                  aligned;
    logic [3:0]            sel;
    logic                  setup_phase;
    logic                  wr_commit;

    assign word_idx    = i_paddr[APB_ADDR_W-1:2];
    assign aligned     = (i_paddr[1:0] == 2'h0);
    assign setup_phase = i_psel && !i_penable;
    // A write lands only at the completing edge of the access phase.
    assign wr_commit   = i_psel && i_penable && pready_reg && i_pwrite && !pslverr_reg;

    always_comb begin
        hit_tx   = aligned && (word_idx >= TX_RING_FIRST_IDX)  && (word_idx <= TX_RING_LAST_IDX);
        hit_rx   = aligned && (word_idx >= RX_RING_FIRST_IDX)  && (word_idx <= RX_RING_LAST_IDX);
        hit_pair = aligned && (word_idx >= PAIR_GRP_FIRST_IDX) && (word_idx <= PAIR_GRP_LAST_IDX);
        hit_ref  = aligned && (word_idx >= REF_SEL_FIRST_IDX)  && (word_idx <= REF_SEL_LAST_IDX);
        idx_ofs  = '0;
        if (hit_tx) begin
            idx_ofs = word_idx - TX_RING_FIRST_IDX;
        end else if (hit_rx) begin
            idx_ofs = word_idx - RX_RING_FIRST_IDX;
        end else if (hit_pair) begin
            idx_ofs = word_idx - PAIR_GRP_FIRST_IDX;
        end else if (hit_ref) begin
            idx_ofs = word_idx - REF_SEL_FIRST_IDX;
        end
        sel = idx_ofs[3:0];
    end

    // Byte-lane merge of a 16-bit register image with the write data.
    function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old_v,
                                                 input logic [APB_DATA_W-1:0] wdata,
                                                 input logic [3:0] strb);
        logic [REG_W-1:0] v;
        v = old_v;
        if (strb[0]) begin
            v[7:0] = wdata[7:0];
        end
        if (strb[1]) begin
            v[15:8] = wdata[15:8];
        end
        return v;
    endfunction

    // Read images. Reserved and unused bits read as zero.
    function automatic logic [REG_W-1:0] ring_image(input rlgc_ring_cfg_t c);
        return {4'h0, c};
    endfunction

    function automatic logic [REG_W-1:0] pair_image(input rlgc_rcmb_cfg_t lo, input rlgc_rcmb_cfg_t hi);
        return {3'h0, hi.enable, 1'b0, hi.group, 3'h0, lo.enable, 1'b0, lo.group};
    endfunction

    function automatic logic [REG_W-1:0] ref_image(input rlgc_ref_cfg_t c, input rlgc_ref_out_t r);
        // Bits 8:5 show the link in force, which moves in automatic mode.
        return {7'h00, r.link, c};
    endfunction

    // Transmit and receive ring registers, one entry per link.
    genvar l;
    generate
        for (l = 0; l < N_LINKS; l++) begin : gen_link
            logic [REG_W-1:0] tx_new;
            logic [REG_W-1:0] rx_new;
            assign tx_new = merge16(ring_image(tx_ring_reg[l]), i_pwdata, i_pstrb);
            assign rx_new = merge16(ring_image(rx_ring_reg[l]), i_pwdata, i_pstrb);

            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    tx_ring_reg[l] <= rlgc_ring_cfg_t'(TX_RING_RESET[RING_CFG_W-1:0]);
                end else if (wr_commit && hit_tx && (sel == 4'(l))) begin
                    tx_ring_reg[l] <= rlgc_ring_cfg_t'(tx_new[RING_CFG_W-1:0]);
                end
            end

            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    rx_ring_reg[l] <= rlgc_ring_cfg_t'(RX_RING_RESET[RING_CFG_W-1:0]);
                end else if (wr_commit && hit_rx && (sel == 4'(l))) begin
                    rx_ring_reg[l] <= rlgc_ring_cfg_t'(rx_new[RING_CFG_W-1:0]);
                end
            end

            // Per-link ring switch selects follow the mode bits.
            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    tx_atm_sel_reg[l] <= 1'b0;
                    tx_tdm_sel_reg[l] <= 1'b0;
                    rx_atm_sel_reg[l] <= 1'b0;
                    rx_tdm_sel_reg[l] <= 1'b0;
                end else begin
                    tx_atm_sel_reg[l] <= tx_ring_reg[l].atm_ring;
                    tx_tdm_sel_reg[l] <= tx_ring_reg[l].tdm_ring;
                    rx_atm_sel_reg[l] <= rx_ring_reg[l].atm_ring;
                    rx_tdm_sel_reg[l] <= rx_ring_reg[l].tdm_ring;
                end
            end
        end
    endgenerate

    // Pair registers: entry p holds link p in the low byte and p plus eight high.
    genvar p;
    generate
        for (p = 0; p < N_PAIRS; p++) begin : gen_pair
            logic [REG_W-1:0] pair_new;
            assign pair_new = merge16(pair_image(rcmb_reg[p], rcmb_reg[p + PAIR_HI_LINK_OFS]), i_pwdata, i_pstrb);

            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    rcmb_reg[p]                    <= rlgc_rcmb_cfg_t'(PAIR_GRP_RESET[3:0]);
                    rcmb_reg[p + PAIR_HI_LINK_OFS] <= rlgc_rcmb_cfg_t'(PAIR_GRP_RESET[3:0]);
                end else if (wr_commit && hit_pair && (sel == 4'(p))) begin
                    rcmb_reg[p].enable                    <= pair_new[PAIR_LO_EN_BIT];
                    rcmb_reg[p].group                     <= pair_new[PAIR_LO_GRP_LSB +: 3];
                    rcmb_reg[p + PAIR_HI_LINK_OFS].enable <= pair_new[PAIR_HI_EN_BIT];
                    rcmb_reg[p + PAIR_HI_LINK_OFS].group  <= pair_new[PAIR_HI_GRP_LSB +: 3];
                end
            end
        end
    endgenerate

    // Reference link registers, one per group.
    genvar g;
    generate
        for (g = 0; g < N_GROUPS; g++) begin : gen_ref
            logic [REG_W-1:0] ref_new;
            assign ref_new = merge16(ref_image(ref_cfg_reg[g], ref_out_reg[g]), i_pwdata, i_pstrb);

            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    ref_cfg_reg[g] <= rlgc_ref_cfg_t'(REF_SEL_RESET[REF_CFG_W-1:0]);
                end else if (wr_commit && hit_ref && (sel == 4'(g))) begin
                    ref_cfg_reg[g].auto_sel <= ref_new[REF_AUTO_BIT];
                    ref_cfg_reg[g].link     <= ref_new[REF_LINK_LSB +: 4];
                end
            end

            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    ref_out_reg[g] <= '{valid: 1'b0, link: 4'h0};
                end else begin
                    ref_out_reg[g] <= ref_out_next[g];
                end
            end
        end
    endgenerate

    rlgc_ref_pick #(
        .N_LINKS  (N_LINKS),
        .N_GROUPS (N_GROUPS)
    ) u_ref_pick (
        .i_rcmb    (rcmb_reg),
        .i_link_up (i_link_up),
        .i_ref     (ref_cfg_reg),
        .o_ref     (ref_out_next)
    );

    // Read data and error are prepared in the setup cycle so that the access
    // phase completes with zero wait states and the answer comes from flops.
    always_comb begin
        prdata_next  = '0;
        pslverr_next = !(hit_tx || hit_rx || hit_pair || hit_ref);
        if (!i_pwrite) begin
            if (hit_tx) begin
                prdata_next[REG_W-1:0] = ring_image(tx_ring_reg[sel]);
            end else if (hit_rx) begin
                prdata_next[REG_W-1:0] = ring_image(rx_ring_reg[sel]);
            end else if (hit_pair) begin
                prdata_next[REG_W-1:0] = pair_image(rcmb_reg[sel[2:0]],
                                                    rcmb_reg[{1'b1, sel[2:0]}]);
            end else if (hit_ref) begin
                prdata_next[REG_W-1:0] = ref_image(ref_cfg_reg[sel[2:0]], ref_out_reg[sel[2:0]]);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else if (setup_phase) begin
            pready_reg  <= 1'b1;
            pslverr_reg <= pslverr_next;
            prdata_reg  <= prdata_next;
        end else begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end
    end

    // Ring drivers follow the global ring enable held in the ring control block.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ring_oe_reg <= 1'b0;
        end else begin
            ring_oe_reg <= i_ring_enable;
        end
    end

    assign o_prdata          = prdata_reg;
    assign o_pready          = pready_reg;
    assign o_pslverr         = pslverr_reg;
    assign o_tx_ring         = tx_ring_reg;
    assign o_rx_ring         = rx_ring_reg;
    assign o_rcmb            = rcmb_reg;
    assign o_ref             = ref_out_reg;
    assign o_tx_atm_ring_sel = tx_atm_sel_reg;
    assign o_tx_tdm_ring_sel = tx_tdm_sel_reg;
    assign o_rx_atm_ring_sel = rx_atm_sel_reg;
    assign o_rx_tdm_ring_sel = rx_tdm_sel_reg;
    assign o_ring_oe         = ring_oe_reg;

endmodule

`default_nettype wire

// File: tb/rlgc_regbank_monitor.sv
// Concurrent checks on the ring and group configuration bank ports.
`timescale 1ns/10ps
`default_nettype none

module rlgc_regbank_monitor
    import rlgc_pkg::*;
#(
    parameter int unsigned N_LINKS = NUM_LINKS
) (
    input wire logic                  i_clk,
    input wire logic                  i_resetn,
    input wire logic [APB_ADDR_W-1:0] i_paddr,
    input wire logic                  i_psel,
    input wire logic                  i_penable,
    input wire logic                  i_pwrite,
    input wire logic [APB_DATA_W-1:0] o_prdata,
    input wire logic                  o_pready,
    input wire logic                  o_pslverr,
    input wire logic                  i_ring_enable,
    input wire rlgc_ring_cfg_t        o_tx_ring [N_LINKS],
    input wire rlgc_ring_cfg_t        o_rx_ring [N_LINKS],
    input wire logic [N_LINKS-1:0]    o_tx_atm_ring_sel,
    input wire logic [N_LINKS-1:0]    o_tx_tdm_ring_sel,
    input wire logic [N_LINKS-1:0]    o_rx_atm_ring_sel,
    input wire logic [N_LINKS-1:0]    o_rx_tdm_ring_sel,
    input wire logic                  o_ring_oe
);
    logic [N_LINKS-1:0] tx_atm;
    logic [N_LINKS-1:0] tx_tdm;
    logic [N_LINKS-1:0] rx_atm;
    logic [N_LINKS-1:0] rx_tdm;
    logic [IDX_W-1:0]   idx;
    logic               rd_ok;

    always_comb begin
        for (int i = 0; i < N_LINKS; i++) begin
            tx_atm[i] = o_tx_ring[i].atm_ring;
            tx_tdm[i] = o_tx_ring[i].tdm_ring;
            rx_atm[i] = o_rx_ring[i].atm_ring;
            rx_tdm[i] = o_rx_ring[i].tdm_ring;
        end
    end
    assign idx   = i_paddr[11:2];
    assign rd_ok = o_pready && !i_pwrite && !o_pslverr;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    a_setup_gets_ready: assert property (i_psel && !i_penable |=> o_pready ##1 !o_pready)
        else $error("ready is not a single cycle after setup");
    a_ready_has_setup: assert property (o_pready |-> $past(i_psel) && !$past(i_penable))
        else $error("ready without a setup cycle before it");
    a_misaligned_refused: assert property (i_psel && !i_penable && i_paddr[1:0] != 2'b00 |=> o_pslverr && o_prdata == 0)
        else $error("misaligned access not refused");
    a_ring_oe_follows: assert property ($past(i_resetn) |-> o_ring_oe == $past(i_ring_enable))
        else $error("ring driver enable does not follow global enable");
    a_tx_atm_sel: assert property ($past(i_resetn) |-> o_tx_atm_ring_sel == $past(tx_atm))
        else $error("tx atm ring select wrong");
    a_tx_tdm_sel: assert property ($past(i_resetn) |-> o_tx_tdm_ring_sel == $past(tx_tdm))
        else $error("tx tdm ring select wrong");
    a_rx_atm_sel: assert property ($past(i_resetn) |-> o_rx_atm_ring_sel == $past(rx_atm))
        else $error("rx atm ring select wrong");
    a_rx_tdm_sel: assert property ($past(i_resetn) |-> o_rx_tdm_ring_sel == $past(rx_tdm))
        else $error("rx tdm ring select wrong");
    a_pair_spare_zero: assert property (rd_ok && idx >= PAIR_GRP_FIRST_IDX && idx <= PAIR_GRP_LAST_IDX
        |-> (o_prdata & 32'hffff_e8e8) == 32'h0000_0000) else $error("pair register spare bits not zero");
    a_tx_readback: assert property (rd_ok && idx >= TX_RING_FIRST_IDX && idx <= TX_RING_LAST_IDX
        |-> o_prdata == {20'h0_0000, o_tx_ring[idx - TX_RING_FIRST_IDX]}) else $error("tx ring read mismatch");
    a_ref_manual_link: assert property (rd_ok && idx >= REF_SEL_FIRST_IDX && idx <= REF_SEL_LAST_IDX
        && !o_prdata[4] && !$past(i_pwrite, 2) |-> o_prdata[8:5] == o_prdata[3:0])
        else $error("manual reference link not in force");

    c_write_commit: cover property (o_pready && i_pwrite && !o_pslverr);
    c_refused: cover property (o_pready && o_pslverr);
    c_ring_on: cover property ($rose(o_ring_oe));
endmodule

`default_nettype wire

// File: tb/tb_rlgc_regbank.sv
// Self-checking bench for the ring and group configuration bank.
`timescale 1ns/10ps
`default_nettype none

module tb_rlgc_regbank;
    import rlgc_pkg::*;
    typedef struct {logic [31:0] data; logic [31:0] mask; logic err;} rlgc_note_t;

    logic                  i_clk = 1'b0;
    logic                  i_resetn = 1'b0;
    logic [APB_ADDR_W-1:0] i_paddr = 12'h000;
    logic                  i_psel = 1'b0;
    logic                  i_penable = 1'b0;
    logic                  i_pwrite = 1'b0;
    logic [APB_DATA_W-1:0] i_pwdata = 32'h0;
    logic [3:0]            i_pstrb = 4'hf;
    logic                  i_ring_enable = 1'b0;
    logic [NUM_LINKS-1:0]  i_link_up = 16'h0;
    logic [APB_DATA_W-1:0] o_prdata;
    logic                  o_pready;
    logic                  o_pslverr;
    logic                  o_ring_oe;
    logic [NUM_LINKS-1:0]  o_tx_atm_ring_sel, o_tx_tdm_ring_sel, o_rx_atm_ring_sel, o_rx_tdm_ring_sel;
    rlgc_ring_cfg_t        o_tx_ring [NUM_LINKS];
    rlgc_ring_cfg_t        o_rx_ring [NUM_LINKS];
    rlgc_rcmb_cfg_t        o_rcmb [NUM_LINKS];
    rlgc_ref_out_t         o_ref [NUM_GROUPS];
    rlgc_note_t            notes [$];
    rlgc_note_t            cur;
    logic [3:0]            rc [NUM_LINKS];
    int                    failures = 0;
    int                    comparisons = 0;

    rlgc_regbank u_dut (
        .i_clk, .i_resetn, .i_paddr, .i_psel, .i_penable, .i_pwrite, .i_pwdata, .i_pstrb, .o_prdata, .o_pready,
        .o_pslverr, .i_ring_enable, .i_link_up, .o_tx_ring, .o_rx_ring, .o_rcmb, .o_ref, .o_tx_atm_ring_sel,
        .o_tx_tdm_ring_sel, .o_rx_atm_ring_sel, .o_rx_tdm_ring_sel, .o_ring_oe
    );

    always #5 i_clk = ~i_clk;

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic complete_run();
        if (failures == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Leaves the bus in its access phase so the next call forms a back-to-back setup.
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [1:0] ofs, input logic [15:0] wd,
                       input logic [3:0] st, input logic [31:0] ed, input logic [31:0] em, input logic ee);
        int n;
        n = 0;
        notes.push_back('{ed, em, ee});
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= {idx, ofs};
        i_pwdata <= {16'($urandom()), wd};
        i_pstrb <= st;
        i_ring_enable <= 1'($urandom());
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1 && n++ < 16);
        if (n >= 16) failures++;
    endtask

    task automatic idle();
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic rd(input logic [9:0] idx, input logic [31:0] ed, input logic [31:0] em = 32'hffff_ffff);
        apb(0, idx, 0, 0, 4'hf, ed, em, 0);
    endtask

    task automatic wr(input logic [9:0] idx, input logic [15:0] wd);
        apb(1, idx, 0, wd, 4'hf, 32'h0, 32'h0, 0);
    endtask

    function automatic logic [4:0] auto_pick(input int g);
        auto_pick = 5'h00;
        for (int l = 15; l >= 0; l--)
            if (rc[l][3] && rc[l][2:0] == 3'(g) && i_link_up[l]) auto_pick = {1'b1, 4'(l)};
    endfunction

    always @(posedge i_clk) begin
        if (o_pready === 1'b1) begin
            if (notes.size() == 0) check("unexpected ready", 32'h0, 32'h1);
            else begin
                cur = notes.pop_front();
                check("prdata", cur.data & cur.mask, o_prdata & cur.mask);
                check("pslverr", {31'h0, cur.err}, {31'h0, o_pslverr});
            end
        end
    end

    initial begin
        logic [15:0] v;
        logic [3:0]  lk;
        void'($urandom(520));
        repeat (8) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        for (int i = 0; i < 16; i++) begin
            rd(TX_RING_FIRST_IDX + 10'(i), 32'h0);
            rd(RX_RING_FIRST_IDX + 10'(i), 32'h0);
        end
        for (int i = 0; i < 8; i++) begin
            rd(PAIR_GRP_FIRST_IDX + 10'(i), 32'h0);
            rd(REF_SEL_FIRST_IDX + 10'(i), 32'h0);
        end
        apb(1, 10'h180, 0, 16'hffff, 4'hf, 32'h0, 32'h0, 1);
        apb(1, TX_RING_FIRST_IDX, 2'h2, 16'hffff, 4'hf, 32'h0, 32'h0, 1);
        apb(0, 10'h191, 0, 0, 4'hf, 32'h0, 32'hffff_ffff, 1);
        rd(TX_RING_FIRST_IDX, 32'h0);
        for (int i = 0; i < 16; i++) begin
            v = 16'($urandom());
            wr(TX_RING_FIRST_IDX + 10'(i), v);
            wr(RX_RING_FIRST_IDX + 10'(i), ~v);
            rd(TX_RING_FIRST_IDX + 10'(i), {20'h0, v[11:0]});
            rd(RX_RING_FIRST_IDX + 10'(i), {20'h0, ~v[11:0]});
            idle();
            check("tx ring", {20'h0, v[11:0]}, {20'h0, o_tx_ring[i]});
            check("rx ring", {20'h0, ~v[11:0]}, {20'h0, o_rx_ring[i]});
            check("ring sel", {28'h0, v[11], v[5], ~v[11], ~v[5]}, {28'h0, o_tx_atm_ring_sel[i],
                  o_tx_tdm_ring_sel[i], o_rx_atm_ring_sel[i], o_rx_tdm_ring_sel[i]});
        end
        for (int p = 0; p < 8; p++) begin
            v = 16'($urandom()) & 16'h1717;
            wr(PAIR_GRP_FIRST_IDX + 10'(p), v);
            rd(PAIR_GRP_FIRST_IDX + 10'(p), {16'h0, v});
            idle();
            rc[p] = {v[4], v[2:0]};
            rc[p + 8] = {v[12], v[10:8]};
            check("rcmb low", {28'h0, rc[p]}, {28'h0, o_rcmb[p]});
            check("rcmb high", {28'h0, rc[p + 8]}, {28'h0, o_rcmb[p + 8]});
        end
        apb(1, PAIR_GRP_FIRST_IDX, 0, 16'h1717, 4'h2, 32'h0, 32'h0, 0);
        rd(PAIR_GRP_FIRST_IDX, {19'h0, 5'h17, 3'h0, rc[0][3], 1'b0, rc[0][2:0]});
        rc[8] = 4'hf;
        for (int g = 0; g < 8; g++) begin
            lk = 4'($urandom());
            wr(REF_SEL_FIRST_IDX + 10'(g), {12'h0, lk});
            rd(REF_SEL_FIRST_IDX + 10'(g), {28'h0, lk}, 32'hffff_fe1f);
            idle();
            check("manual ref", {27'h0, 1'b1, lk}, {27'h0, o_ref[g]});
        end
        for (int g = 0; g < 8; g++) wr(REF_SEL_FIRST_IDX + 10'(g), 16'h0010);
        idle();
        repeat (8) begin
            i_link_up <= 16'($urandom());
            repeat (2) @(posedge i_clk);
            for (int g = 0; g < 8; g++) check("auto ref", {27'h0, auto_pick(g)}, {27'h0, o_ref[g]});
            rd(REF_SEL_FIRST_IDX, 32'h10, 32'hffff_fe1f);
            idle();
        end
        complete_run();
    end

    initial begin
        #200000;
        failures++;
        complete_run();
    end
endmodule

bind rlgc_regbank rlgc_regbank_monitor #(.N_LINKS(N_LINKS)) u_mon (
    .i_clk, .i_resetn, .i_paddr, .i_psel, .i_penable, .i_pwrite, .o_prdata, .o_pready, .o_pslverr,
    .i_ring_enable, .o_tx_ring, .o_rx_ring, .o_tx_atm_ring_sel, .o_tx_tdm_ring_sel, .o_rx_atm_ring_sel,
    .o_rx_tdm_ring_sel, .o_ring_oe
);

`default_nettype wire
